// [dv/eeprom_cmd_monitor.sv]
// Purpose: Port checker for the serial EEPROM command logic.
// Assumes: Serial pins are slow against clk_in.
// Notes: Margins cover the pin synchronisers.
`timescale 1ns/1ns
module eeprom_cmd_monitor #(
	parameter WRITE_CYCLES = 500000
) (
	input wire clk_in, // Clock
	input wire rst_in, // Reset
	input wire cs_n_in, // Select
	input wire sck_in, // Serial clock
	input wire hold_n_in, // Pause
	input wire wp_n_in, // Protect
	input wire so_out, // Data out
	input wire so_oe_out, // Out enable
	input wire busy_out // Busy
);
	int busy_cycles;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			busy_cycles <= 0;
		else
			busy_cycles <= busy_out ? busy_cycles + 1 : 0;
	end
	chk_deselect_quiet:
	assert property (cs_n_in [*6] |-> !so_oe_out)
		else $error("output driven while deselected");
	chk_oe_selected:
	assert property (so_oe_out |-> !$past(cs_n_in, 4))
		else $error("output driven after deselect");
	chk_hold_quiet:
	assert property (!hold_n_in [*6] |-> !so_oe_out)
		else $error("output driven while paused");
	chk_oe_start_ok:
	assert property ($rose(so_oe_out) |-> !cs_n_in && hold_n_in)
		else $error("output enabled at wrong time");
	chk_so_after_rise:
	assert property (so_oe_out && $past(so_oe_out) && $changed(so_out) |-> sck_in || $past(sck_in, 2))
		else $error("output moved away from clock rise");
	chk_busy_length:
	assert property ($fell(busy_out) |-> busy_cycles == WRITE_CYCLES)
		else $error("write cycle length wrong");
	chk_commit_deselect:
	assert property ($rose(busy_out) |-> cs_n_in && $past(cs_n_in, 2))
		else $error("write started while selected");
	chk_commit_wp:
	assert property ($rose(busy_out) |-> wp_n_in)
		else $error("write started while protected");
	cover property ($rose(busy_out));
	cover property ($rose(so_oe_out));
	cover property (!hold_n_in && !cs_n_in);
endmodule

bind eeprom_cmd eeprom_cmd_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon (.clk_in(clk_in), .rst_in(rst_in),
	.cs_n_in(cs_n_in), .sck_in(sck_in), .hold_n_in(hold_n_in), .wp_n_in(wp_n_in), .so_out(so_out),
	.so_oe_out(so_oe_out), .busy_out(busy_out));

// [dv/spi_host_model.sv]
// Purpose: Host controller model driving the serial link, clock idle low.
// Assumes: Half period of six clk_in cycles.
// Notes: Data in toggles between frames; a released output reads as the inverse of its last level.
`timescale 1ns/1ns
module spi_host_model (
	input wire clk_in, // Clock
	input wire so_in, // Device data out
	input wire so_oe_in, // Device out enable
	output logic cs_n_out, // Select
	output logic sck_out, // Serial clock
	output logic si_out, // Data to device
	output logic hold_n_out // Pause
);
	int pause_at = -1;
	logic [7:0] oe_bits = 8'h00;
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
		hold_n_out = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic start();
		tick(6);
		cs_n_out <= 1'b0;
		tick(6);
	endtask
	task automatic stop();
		tick(6);
		cs_n_out <= 1'b1;
		si_out <= ~si_out;
		tick(8);
	endtask
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		oe_bits = 8'h00;
		for (int i = 7; i >= 8 - nb; i--) begin
			sck_out <= 1'b1;
			tick(3);
			si_out <= tx[i];
			if (i == pause_at) begin
				hold_n_out <= 1'b0;
				tick(40);
				hold_n_out <= 1'b1;
			end
			tick(3);
			// A released line floats; showing the inverse makes a missing drive visible
			rx[i] = so_oe_in ? so_in : ~so_in;
			oe_bits[i] = so_oe_in;
			sck_out <= 1'b0;
			tick(6);
		end
	endtask
endmodule

// [dv/test_spi_eeprom_command_logic.sv]
// Purpose: Directed test of the serial EEPROM command logic.
// Assumes: Write cycle shortened to 400 clocks.
// Notes: Array contents start undefined, so only written places are read.
`timescale 1ns/1ns
module test_spi_eeprom_command_logic;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wp_n_in = 1'b1;
	wire cs_n, sck, si, hold_n, so, so_oe, busy;
	int fail_count = 0;
	int checks = 0;
	logic [7:0] rx;
	eeprom_cmd #(.WRITE_CYCLES(400)) dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .cs_n_in(cs_n),
		.sck_in(sck), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in), .so_out(so),
		.so_oe_out(so_oe), .busy_out(busy));
	spi_host_model host (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n), .sck_out(sck),
		.si_out(si), .hold_n_out(hold_n));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	task automatic complete_run();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic op(input logic [7:0] code);
		host.start();
		host.xfer(code, 8, rx);
		host.stop();
	endtask
	task automatic status(input logic [7:0] exp);
		host.start();
		host.xfer(8'h05, 8, rx);
		host.xfer(8'h00, 8, rx);
		host.stop();
		chk("status", exp, rx);
		chk("status enable", 8'hFF, host.oe_bits);
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] q[$]);
		host.start();
		host.xfer(cmd, 8, rx);
		foreach (q[i]) host.xfer(q[i], 8, rx);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] addr, input logic [7:0] q[$]);
		host.start();
		host.xfer(8'h03, 8, rx);
		host.xfer(addr, 8, rx);
		foreach (q[i]) begin
			host.xfer(8'h00, 8, rx);
			chk("read", q[i], rx);
		end
		host.stop();
	endtask
	task automatic idle_chk();
		for (int n = 0; n < 600 && busy !== 1'b0; n++) @(posedge clk_in);
		chk("busy", 8'h00, {7'h00, busy});
	endtask
	initial begin
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		status(8'h00);
		op(8'h06);
		status(8'h02);
		op(8'h04);
		status(8'h00);
		op(8'h06);
		wr(8'h02, '{8'hFE, 8'h11, 8'h22});
		status(8'hFF);
		idle_chk();
		status(8'h00);
		op(8'h06);
		host.pause_at = 4;
		wr(8'h02, '{8'h00, 8'h33});
		idle_chk();
		host.pause_at = 3;
		rd(8'hFE, '{8'h11, 8'h22, 8'h33});
		host.pause_at = -1;
		op(8'h06);
		wr(8'h01, '{8'hF7});
		idle_chk();
		status(8'h04);
		op(8'h06);
		wr(8'h02, '{8'hFE, 8'h44});
		chk("busy", 8'h00, {7'h00, busy});
		wr(8'h02, '{8'hBE, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5});
		idle_chk();
		rd(8'hBC, '{8'hA3, 8'hA4, 8'hA5, 8'hA2});
		rd(8'hFE, '{8'h11});
		op(8'h06);
		host.start();
		host.xfer(8'h02, 8, rx);
		wp_n_in <= 1'b0;
		host.xfer(8'h00, 8, rx);
		wp_n_in <= 1'b1;
		host.xfer(8'h99, 8, rx);
		host.stop();
		chk("busy", 8'h00, {7'h00, busy});
		host.start();
		host.xfer(8'h02, 8, rx);
		host.xfer(8'h00, 8, rx);
		host.xfer(8'h5A, 8, rx);
		host.xfer(8'h6B, 3, rx);
		host.stop();
		chk("busy", 8'h00, {7'h00, busy});
		wr(8'h06, '{8'h02, 8'h00, 8'h77});
		chk("busy", 8'h00, {7'h00, busy});
		wp_n_in <= 1'b0;
		wr(8'h02, '{8'h10, 8'h55});
		chk("busy", 8'h00, {7'h00, busy});
		status(8'h06);
		wp_n_in <= 1'b1;
		wr(8'hFF, '{8'h00});
		chk("released", 8'h00, host.oe_bits);
		rd(8'h00, '{8'h33});
		complete_run();
	end
	initial begin
		// About three times the roughly 10,000 clocks that the tests take
		#300_000;
		fail_count++;
		complete_run();
	end
endmodule

// [rtl/eeprom_cmd.v]
// Purpose: Slave-side command logic of a 256-byte serial EEPROM with block protection.
// Assumes: Serial pins are oversampled by clk_in, so the serial clock must stay well below clk_in/4.
// Notes: Write bytes pass through a FIFO and are drained into the array during the self-timed write.
`timescale 1ns/1ns
`include "eeprom_cmd_map.vh"

module byte_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW = `FIFO_ADDR_BITS
) (
	input wire clk_in, // System clock
	input wire rst_in, // Asynchronous reset, active high
	input wire ce_in, // Clock enable
	input wire flush_in, // Discard all entries
	input wire wr_valid_in, // Entry offered
	input wire [WIDTH-1:0] wr_data_in, // Entry data
	output wire wr_ready_out, // Room for an entry
	output wire rd_valid_out, // Entry available
	output wire [WIDTH-1:0] rd_data_out, // Oldest entry
	input wire rd_ready_in // Consumer takes entry
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign wr_ready_out = (count != DEPTH[AW:0]);
	assign rd_valid_out = (count != {(AW+1){1'b0}});
	assign rd_data_out = store[rd_ptr];
	assign push = wr_valid_in & wr_ready_out & ~flush_in;
	assign pop = rd_valid_out & rd_ready_in & ~flush_in;

	always @(posedge clk_in) begin
		if (ce_in && push) begin
			store[wr_ptr] <= wr_data_in;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else if (ce_in) begin
			if (flush_in) begin
				wr_ptr <= {AW{1'b0}};
				rd_ptr <= {AW{1'b0}};
				count <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					wr_ptr <= wr_ptr + 1'b1;
				end
				if (pop) begin
					rd_ptr <= rd_ptr + 1'b1;
				end
				if (push && !pop) begin
					count <= count + 1'b1;
				end else if (pop && !push) begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule

// Overview of operation
// R1 - Opcode, address and write data are sampled on serial clock falling edges.
// R2 - Read data changes after serial clock rising edges.
// R3 - First input bit is the first falling edge after select goes low.
// R4 - Deselected: output high impedance; standby unless an internal write runs.
// R5 - After power-up nothing is accepted until select has fallen once.
// R6 - Host keeps select low for the whole operation.
// R7 - Eight instruction bits are shifted in, then decoded.
// R8 - Everything travels most significant bit first.
// R9 - Serial clock may stop any time; the operation continues later.
// R10 - Host changes the pause input only while serial clock is high.
// R11 - Pause freezes the sequence; it resumes exactly where it stopped.
// R12 - Write protect low refuses all nonvolatile writes only.
// R13 - Protect falling while selected abandons the pending write, not a started one.
// R14 - Opcodes 06 and 04 set and clear the write latch; writes need it.
// R15 - Write latch clears at power-up and after every write cycle.
// R16 - Opcode 05 shifts status out at any time, even while busy.
// R17 - Status bits: 0 busy, 1 latch, 2-3 protect level, 4-7 unused.
// R18 - Opcode 01 writes protect bits; busy and latch are device-owned.
// R19 - Busy reads 1 during a write and all other status bits read 1.
// R20 - Protect level 00 none, 01 C0-FF, 10 80-FF, 11 all; reads allowed.
// R21 - Opcode 03 plus address streams array data from that address.
// R22 - Opcode 02 plus address and data writes array, subject to checks.
// R23 - Read address increments per byte and wraps from FF to 00.
// R24 - Write address wraps within a four-byte page.
// R25 - Write starts only if select rises right after a complete data byte.
// R26 - A write in the same select frame as the latch-set opcode is ignored.
// R27 - Unknown opcodes are ignored with the output off until deselect.
// R28 - A committed write runs self-timed with busy set throughout.
module eeprom_cmd #(
	parameter WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
	input wire clk_in, // System clock, 100 MHz
	input wire rst_in, // Asynchronous reset, active high (power-up)
	input wire ce_in, // Clock enable, freezes all state when low
	input wire cs_n_in, // Chip select pin, active low
	input wire sck_in, // Serial clock pin
	input wire si_in, // Serial data in pin
	input wire hold_n_in, // Pause pin, active low
	input wire wp_n_in, // Write protect pin, active low
	output reg so_out, // Serial data out level
	output wire so_oe_out, // Serial data out enable, high while driven
	output wire busy_out // Internal write in progress
);
	localparam ST_IDLE = 3'd0;
	localparam ST_OPC = 3'd1;
	localparam ST_ADDR = 3'd2;
	localparam ST_RDATA = 3'd3;
	localparam ST_SOUT = 3'd4;
	localparam ST_WDATA = 3'd5;
	localparam ST_SDATA = 3'd6;
	localparam ST_IGNORE = 3'd7;

	reg [7:0] mem [0:255];
	reg [4:0] sync_a;
	reg [4:0] sync_b;
	reg sck_d;
	reg cs_d;
	reg wp_d;
	reg armed;
	reg [2:0] state;
	reg [7:0] shreg;
	reg [2:0] bitcnt;
	reg [2:0] outcnt;
	reg [7:0] outsh;
	reg [7:0] addr;
	reg is_write;
	reg got_byte;
	reg abort;
	reg latch_flag;
	reg [1:0] protect_level;
	reg [1:0] pend_level;
	reg busy_flag;
	reg status_job;
	reg [31:0] timer;
	wire si_s;
	wire sck_s;
	wire cs_n_s;
	wire hold_n_s;
	wire wp_n_s;
	wire paused;
	wire act;
	wire sck_fall;
	wire sck_rise;
	wire cs_fall;
	wire cs_rise;
	wire [7:0] in_byte;
	wire byte_done;
	wire [7:0] status_val;
	wire prot_hit;
	wire commit_array;
	wire commit_status;
	wire fifo_ready;
	wire fifo_valid;
	wire [15:0] fifo_data;
	wire fifo_flush;
	wire push;
	wire drain;

	assign si_s = sync_b[0];
	assign sck_s = sync_b[1];
	assign cs_n_s = sync_b[2];
	assign hold_n_s = sync_b[3];
	assign wp_n_s = sync_b[4];

	// Pause only counts while selected; its release is taken with sck high so no edge is lost
	assign paused = ~hold_n_s & ~cs_n_s; // R11
	assign act = armed & ~cs_n_s & ~paused; // R5 R11
	// Edges are taken from the oversampled clock, so a stopped clock simply yields no edges
	assign sck_fall = act & sck_d & ~sck_s; // R1 R9
	assign sck_rise = act & ~sck_d & sck_s; // R2
	assign cs_fall = cs_d & ~cs_n_s;
	assign cs_rise = ~cs_d & cs_n_s;
	assign in_byte = {shreg[6:0], si_s}; // R8
	assign byte_done = sck_fall & (bitcnt == 3'd7);

	assign status_val = busy_flag ? `STATUS_WHILE_BUSY :
		{4'h0, protect_level, latch_flag, 1'b0}; // R17 R19

	assign prot_hit = (protect_level == 2'b11) ||
		(protect_level == 2'b10 && addr >= `PROTECT_HALF_BASE) ||
		(protect_level == 2'b01 && addr >= `PROTECT_QUARTER_BASE); // R20

	// Commit only at a byte boundary with at least one full data byte received
	assign commit_array = cs_rise & (state == ST_WDATA) & got_byte & (bitcnt == 3'd0) &
		latch_flag & wp_n_s & ~abort & fifo_valid; // R25 R12 R13 R14
	assign commit_status = cs_rise & (state == ST_SDATA) & got_byte & (bitcnt == 3'd0) &
		latch_flag & wp_n_s & ~abort; // R25 R12 R13 R14
	assign fifo_flush = cs_rise & ~commit_array & ~busy_flag;

	// A full FIFO refuses further bytes; they are lost, as a page holds only four anyway
	assign push = byte_done & (state == ST_WDATA) & ~prot_hit; // R20 R22
	assign drain = busy_flag & ~status_job;

	assign so_oe_out = act & ((state == ST_RDATA) || (state == ST_SOUT)); // R4 R27
	assign busy_out = busy_flag;

	byte_fifo #(
		.WIDTH(16),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_ADDR_BITS)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.flush_in(fifo_flush),
		.wr_valid_in(push),
		.wr_data_in({addr, in_byte}),
		.wr_ready_out(fifo_ready),
		.rd_valid_out(fifo_valid),
		.rd_data_out(fifo_data),
		.rd_ready_in(drain)
	);

	// The array is nonvolatile, so it has no reset
	always @(posedge clk_in) begin
		if (ce_in && drain && fifo_valid) begin
			mem[fifo_data[15:8]] <= fifo_data[7:0]; // R24
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_a <= 5'h00;
			sync_b <= 5'h00;
			sck_d <= 1'b0;
			cs_d <= 1'b0;
			wp_d <= 1'b0;
		end else if (ce_in) begin
			sync_a <= {wp_n_in, hold_n_in, cs_n_in, sck_in, si_in};
			sync_b <= sync_a;
			sck_d <= sck_s;
			cs_d <= cs_n_s;
			wp_d <= wp_n_s;
		end
	end

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			armed <= 1'b0;
			state <= ST_IDLE;
			shreg <= 8'h00;
			bitcnt <= 3'd0;
			outcnt <= 3'd0;
			outsh <= 8'h00;
			addr <= 8'h00;
			is_write <= 1'b0;
			got_byte <= 1'b0;
			abort <= 1'b0;
			latch_flag <= 1'b0; // R15
			protect_level <= `PROTECT_RESET;
			pend_level <= `PROTECT_RESET;
			busy_flag <= 1'b0;
			status_job <= 1'b0;
			timer <= 32'h0000_0000;
			so_out <= 1'b0;
		end else if (ce_in) begin
			if (cs_fall) begin
				armed <= 1'b1; // R5
				state <= ST_OPC; // R3
				bitcnt <= 3'd0;
				got_byte <= 1'b0;
				abort <= 1'b0;
			end else if (cs_rise) begin
				state <= ST_IDLE; // R4
				if (commit_array || commit_status) begin
					busy_flag <= 1'b1; // R28
					timer <= 32'h0000_0000;
					status_job <= commit_status;
				end
			end else begin
				if (!cs_n_s && wp_d && !wp_n_s) begin
					abort <= 1'b1; // R13
				end
				if (sck_fall) begin
					shreg <= in_byte; // R1 R7
					bitcnt <= bitcnt + 3'd1;
				end
				if (byte_done) begin
					case (state)
						ST_OPC: begin
							if (busy_flag && in_byte != `STATUS_READ_CMD) begin
								state <= ST_IGNORE;
							end else begin
								case (in_byte) // R7
									`SET_WRITE_LATCH_CMD: begin
										latch_flag <= 1'b1; // R14
										state <= ST_IGNORE; // R26
									end
									`CLEAR_WRITE_LATCH_CMD: begin
										latch_flag <= 1'b0; // R14
										state <= ST_IGNORE;
									end
									`STATUS_READ_CMD: begin
										outsh <= status_val; // R16
										outcnt <= 3'd0;
										state <= ST_SOUT;
									end
									`STATUS_WRITE_CMD: begin
										state <= ST_SDATA; // R18
									end
									`ARRAY_READ_CMD: begin
										is_write <= 1'b0;
										state <= ST_ADDR; // R21
									end
									`ARRAY_WRITE_CMD: begin
										is_write <= 1'b1;
										state <= ST_ADDR; // R22
									end
									default: begin
										state <= ST_IGNORE; // R27
									end
								endcase
							end
						end
						ST_ADDR: begin
							if (is_write) begin
								addr <= in_byte;
								state <= ST_WDATA; // R22
							end else begin
								outsh <= mem[in_byte]; // R21
								addr <= in_byte + 8'h01;
								outcnt <= 3'd0;
								state <= ST_RDATA;
							end
						end
						ST_WDATA: begin
							got_byte <= 1'b1;
							if (fifo_ready || prot_hit) begin
								addr <= {addr[7:2], addr[1:0] + 2'd1}; // R24
							end
						end
						ST_SDATA: begin
							got_byte <= 1'b1;
							pend_level <= in_byte[`PROTECT_LEVEL_HI_BIT:`PROTECT_LEVEL_LO_BIT]; // R18
						end
						default: begin
							state <= state;
						end
					endcase
				end
				if (sck_rise && (state == ST_RDATA || state == ST_SOUT)) begin
					so_out <= outsh[7]; // R2 R8
					outcnt <= outcnt + 3'd1;
					if (outcnt == 3'd7) begin
						if (state == ST_RDATA) begin
							outsh <= mem[addr]; // R23
							addr <= addr + 8'h01; // R23
						end else begin
							outsh <= status_val; // R16
						end
					end else begin
						outsh <= {outsh[6:0], 1'b0};
					end
				end
			end
			// Self-timed write; a later fall of write protect no longer matters here
			if (busy_flag) begin
				timer <= timer + 32'h0000_0001;
				if (timer == WRITE_CYCLES - 1) begin
					busy_flag <= 1'b0; // R28
					latch_flag <= 1'b0; // R15
					if (status_job) begin
						protect_level <= pend_level; // R18
					end
				end
			end
		end
	end
endmodule

// [rtl/eeprom_cmd_map.vh]
// Purpose: Constants for the serial EEPROM command logic.
// Assumes: 100 MHz system clock; all serial pins are asynchronous to it.
// Notes: Times are in ns; cycle counts are derived in the module.
`ifndef EEPROM_CMD_MAP_VH
`define EEPROM_CMD_MAP_VH

`define SET_WRITE_LATCH_CMD 8'h06
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define STATUS_READ_CMD 8'h05
`define STATUS_WRITE_CMD 8'h01
`define ARRAY_READ_CMD 8'h03
`define ARRAY_WRITE_CMD 8'h02

`define BUSY_FLAG_BIT 0
`define LATCH_FLAG_BIT 1
`define PROTECT_LEVEL_LO_BIT 2
`define PROTECT_LEVEL_HI_BIT 3
`define STATUS_WHILE_BUSY 8'hFF
`define PROTECT_RESET 2'h0

`define PROTECT_QUARTER_BASE 8'hC0
`define PROTECT_HALF_BASE 8'h80

`define CLK_PERIOD_NS 10
`define WRITE_TIME_NS 5000000
`define FIFO_DEPTH 16
`define FIFO_ADDR_BITS 4

`endif
